// ===== smw_defs.svh
// Timing counts, command bit positions and reset values of the mode and watchdog control
`ifndef SMW_DEFS_SVH
`define SMW_DEFS_SVH

`define SMW_CLK_MHZ          125
`define SMW_RESET_HOLD_MS    1
`define SMW_RESET_HOLD_CYC   (`SMW_RESET_HOLD_MS * `SMW_CLK_MHZ * 1000)
`define SMW_NR_TIMEOUT_MS    150
`define SMW_NR_TIMEOUT_CYC   (`SMW_NR_TIMEOUT_MS * `SMW_CLK_MHZ * 1000)
`define SMW_WD_DEFAULT_MS    150
`define SMW_WD_DEFAULT_CYC   (`SMW_WD_DEFAULT_MS * `SMW_CLK_MHZ * 1000)
`define SMW_INT_PULSE_US     10
`define SMW_INT_PULSE_CYC    (`SMW_INT_PULSE_US * `SMW_CLK_MHZ)

`define SMW_SPI_BITS         4'h8

// Write byte fields
`define SMW_WR_SLEW_HI       7
`define SMW_WR_SLEW_LO       6
`define SMW_WR_PULLUP        5
`define SMW_WR_SW_LO         2
`define SMW_WR_MODE_HI       1
`define SMW_WR_MODE_LO       0
`define SMW_LP_SELECT        2'h3
`define SMW_MODE_SLEEP       2'h0
`define SMW_MODE_STOP        2'h1
`define SMW_MODE_WDCLR       2'h2

// Reset values
`define SMW_SLEW_RST         2'h0
`define SMW_SW_EN_RST        3'h0
`define SMW_PULLUP_RST       1'h0

`endif

// ===== smw_host_model.sv
// Host controller model on the SPI pins
`timescale 1ns/1ns

module smw_host_model (
  input  wire logic clock,    // Clock
  input  wire logic spi_miso, // Data in
  output logic      spi_sclk, // SPI clock
  output logic      spi_mosi, // Data out
  output logic      spi_csn   // Select, low active
);
  initial begin
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    spi_csn  = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic xfer(input logic [7:0] wr, output logic [7:0] rd);
    spi_csn = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = wr[i];
      tick(10);
      rd[i]    = spi_miso;
      spi_sclk = 1'b1;
      tick(10);
      spi_sclk = 1'b0;
    end
    tick(10);
    spi_csn  = 1'b1;
    // Released line must not keep the last bit
    spi_mosi = ~spi_mosi;
    tick(10);
  endtask : xfer
endmodule : smw_host_model

// ===== smw_mode_ctrl.sv
// Operating modes, window watchdog, wake, supply flags and switch control
`timescale 1ns/1ns
`include "smw_defs.svh"

//Contract
// - Watchdog selected unless the configuration pin is tied to ground.
// - Open pin uses the default period; resistor gives its own period.
// - Watchdog fails on a clear in closed window or on no clear.
// - Sleep needs request then command; stop needs request then stop command.
// - Wake on either wake input change, LIN wake or select rising.
// - Supply over or under voltage sets its flag and an unmaskable interrupt.
// - Supply flag clears only after being read and the fault gone.
// - Normal mode reads show live state of both wake inputs.
// - Switches a and b are enable bit AND PWM input.
// - Over-temperature latches switch off until enable rewritten to one.
// - Switch c follows its enable bit only.
// - Sense amplifier enabled in normal mode only.
// - Two mode bits select sleep, stop or normal.
// - Reset mode holds reset low 1ms, releases if regulator good.
// - Normal request runs 150ms timeout; reset on timeout or undervoltage. Timeout only runs when the watchdog is selected.
// - Normal runs window watchdog; reset on undervoltage or watchdog fail.
// - Stop keeps limited regulator, watchdog and switches off, wakes.
// - Sleep turns regulator off, reset low; wake goes to normal request.
// - Interrupt reports faults and wake from stop.
// - Watchdog cleared by write of normal-with-clear mode bits.
// - Low power entered on second of two identical commands.
// - Interrupt is a low pulse of about 10 microseconds.
module smw_mode_ctrl #(
  parameter smw_pkg::smw_count_t RESET_HOLD_CYC = `SMW_RESET_HOLD_CYC,  // Reset hold
  parameter smw_pkg::smw_count_t NR_TIMEOUT_CYC = `SMW_NR_TIMEOUT_CYC,  // Normal request limit
  parameter smw_pkg::smw_count_t WD_DEFAULT_CYC = `SMW_WD_DEFAULT_CYC   // Open pin period
) (
  input  wire logic        clock,               // System clock 125 MHz
  input  wire logic        srst,                // Synchronous reset, power on
  input  wire logic        spi_sclk,            // SPI clock pin
  input  wire logic        spi_mosi,            // SPI data in pin
  input  wire logic        spi_csn,             // SPI chip select, low active
  output logic             spi_miso,            // SPI data out
  input  wire logic        pwm_in,              // PWM gate for switches a, b
  input  wire logic        wake_input_a,        // Switch wake input a
  input  wire logic        wake_input_b,        // Switch wake input b
  input  wire logic        lin_wake,            // LIN bus wake detect
  input  wire logic        supply_ov_cond,      // Supply above high threshold
  input  wire logic        supply_uv_cond,      // Supply below low threshold
  input  wire logic        vdd_in_spec,         // Regulator above threshold
  input  wire logic        vdd_temp_warn,       // Regulator temperature warning
  input  wire logic [2:0]  switch_overtemp,     // Per switch over-temperature
  input  wire logic        wdc_grounded,        // Config pin tied to ground
  input  wire logic        wdc_open,            // Config pin open
  input  wire logic [31:0] wd_res_period_cyc,   // Resistor period in cycles
  output logic             reset_n,             // Reset output, low active
  output logic             int_n,               // Interrupt output, low active
  output logic             regulator_on,        // Regulator enable
  output logic             regulator_limited,   // Regulator low current
  output logic             high_side_switch_a,  // Switch a drive
  output logic             high_side_switch_b,  // Switch b drive
  output logic             high_side_switch_c,  // Switch c drive
  output logic             amp_enable,          // Sense amplifier enable
  output logic             lin_tx_enable,       // LIN transmit and receive active
  output logic             lin_pullup_off,      // LIN pull-up removed
  output logic [1:0]       lin_slew             // LIN slew rate select
);

  // Pin inputs: pwm, wa, wb, lin, ov, uv, vdd, temp, ot[3], gnd, open
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;

  always_ff @(posedge clock) begin
    if (srst) begin
      sync1 <= 13'h0000;
      sync2 <= 13'h0000;
    end else begin
      sync1 <= {pwm_in, wake_input_a, wake_input_b, lin_wake, supply_ov_cond,
                supply_uv_cond, vdd_in_spec, vdd_temp_warn, switch_overtemp,
                wdc_grounded, wdc_open};
      sync2 <= sync1;
    end
  end

  logic       pwm_s, wa_s, wb_s, lin_s, ov_c, uv_c, vdd_s, temp_s, gnd_s, open_s;
  logic [2:0] ot_s;
  assign {pwm_s, wa_s, wb_s, lin_s, ov_c, uv_c, vdd_s, temp_s, ot_s, gnd_s, open_s} = sync2;

  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       cs_fall;
  logic       cs_rise;
  logic [7:0] status_byte;

  smw_spi_slave u_spi (
    .clock    (clock),
    .srst     (srst),
    .spi_sclk (spi_sclk),
    .spi_mosi (spi_mosi),
    .spi_csn  (spi_csn),
    .tx_byte  (status_byte),
    .rx_byte  (rx_byte),
    .rx_valid (rx_valid),
    .cs_fall  (cs_fall),
    .cs_rise  (cs_rise),
    .spi_miso (spi_miso)
  );

  smw_pkg::smw_mode_e  mode, next_mode;
  smw_pkg::smw_count_t tmr, next_tmr;
  smw_pkg::smw_count_t wd_cnt, next_wd_cnt;
  logic [15:0] int_cnt, next_int_cnt;
  logic        int_src, next_int_src;
  logic        ov_flag, next_ov_flag, ov_read, next_ov_read;
  logic        uv_flag, next_uv_flag, uv_read, next_uv_read;
  logic [2:0]  ot_latch, next_ot_latch;
  logic [2:0]  sw_en, next_sw_en;
  logic [1:0]  next_slew;
  logic        pullup_bit, next_pullup_bit;
  logic        lp_pend, next_lp_pend;
  logic [7:0]  lp_byte, next_lp_byte;
  logic        wa_prev, wb_prev, lin_prev, temp_prev;
  logic [2:0]  wake_src, next_wake_src;
  logic        next_reset_n, next_int_n;

  logic                wd_sel, wd_closed, wd_fail, wd_clear, is_lp, lp_enter;
  logic                wake_evt, int_evt, sw_allowed, wr;
  smw_pkg::smw_count_t wd_period;

  assign wr = rx_valid;
  assign wd_sel    = ~gnd_s;
  assign wd_period = open_s ? WD_DEFAULT_CYC : wd_res_period_cyc;
  assign wd_closed = wd_cnt < (wd_period >> 1);
  assign wd_clear  = wr && rx_byte[`SMW_WR_MODE_HI:`SMW_WR_MODE_LO] == `SMW_MODE_WDCLR;
  assign wd_fail   = wd_sel && ((wd_clear && wd_closed) || wd_cnt >= wd_period - 32'h1);
  // low power select with mode bit high clear
  assign is_lp     = wr && rx_byte[`SMW_WR_SLEW_HI:`SMW_WR_SLEW_LO] == `SMW_LP_SELECT
                     && !rx_byte[`SMW_WR_MODE_HI];
  assign lp_enter  = is_lp && lp_pend && rx_byte == lp_byte;
  assign wake_evt  = (wa_s != wa_prev) || (wb_s != wb_prev) || (lin_s && !lin_prev) || cs_rise;

  // live inputs in normal, latched wake source otherwise
  assign status_byte = {int_src, wake_src[2], ov_flag, uv_flag, temp_s, |ot_latch,
                        wake_src[1] | (wb_s && mode == smw_pkg::SMW_NORMAL),
                        wake_src[0] | (wa_s && mode == smw_pkg::SMW_NORMAL)};

  always_comb begin
    next_mode   = mode;
    next_tmr    = tmr + 32'h1;
    next_wd_cnt = wd_cnt;
    case (mode)
      smw_pkg::SMW_RESET: begin
        // hold then release on good regulator
        if (tmr >= RESET_HOLD_CYC - 32'h1 && vdd_s) begin
          next_mode = smw_pkg::SMW_NORMAL_REQ;
          next_tmr  = 32'h0;
        end
      end
      smw_pkg::SMW_NORMAL_REQ: begin
        if ((reset_n && !vdd_s) || (wd_sel && tmr >= NR_TIMEOUT_CYC - 32'h1)) begin
          next_mode = smw_pkg::SMW_RESET;
          next_tmr  = 32'h0;
        end else if (lp_enter) begin
          next_mode = rx_byte[`SMW_WR_MODE_LO] ? smw_pkg::SMW_STOP : smw_pkg::SMW_SLEEP;
        end else if (wd_clear) begin
          next_mode   = smw_pkg::SMW_NORMAL;
          next_wd_cnt = 32'h0;
        end
      end
      smw_pkg::SMW_NORMAL: begin
        next_wd_cnt = wd_cnt + 32'h1;
        if (!vdd_s || wd_fail) begin
          next_mode = smw_pkg::SMW_RESET;
          next_tmr  = 32'h0;
        // mode bits choose stop or sleep
        end else if (lp_enter) begin
          next_mode = rx_byte[`SMW_WR_MODE_LO] ? smw_pkg::SMW_STOP : smw_pkg::SMW_SLEEP;
        end else if (wd_clear) begin
          next_wd_cnt = 32'h0;
        end
      end
      smw_pkg::SMW_STOP: begin
        // undervoltage reset, wake to normal request
        if (!vdd_s) begin
          next_mode = smw_pkg::SMW_RESET;
          next_tmr  = 32'h0;
        end else if (wake_evt) begin
          next_mode = smw_pkg::SMW_NORMAL_REQ;
          next_tmr  = 32'h0;
        end
      end
      smw_pkg::SMW_SLEEP: begin
        // wake restores regulator in normal request
        if (wake_evt) begin
          next_mode = smw_pkg::SMW_NORMAL_REQ;
          next_tmr  = 32'h0;
        end
      end
      default: begin
        next_mode = smw_pkg::SMW_RESET;
        next_tmr  = 32'h0;
      end
    endcase
  end

  // per switch latch, set wins over rewrite
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ot
      assign next_ot_latch[gi] = ot_s[gi] |
                                 (ot_latch[gi] & ~(wr & rx_byte[`SMW_WR_SW_LO + gi]));
    end
  endgenerate

  always_comb begin
    next_sw_en      = sw_en;
    next_slew       = lin_slew;
    next_pullup_bit = pullup_bit;
    next_lp_pend    = lp_pend;
    next_lp_byte    = lp_byte;
    if (wr) begin
      next_sw_en      = rx_byte[`SMW_WR_SW_LO +: 3];
      next_pullup_bit = rx_byte[`SMW_WR_PULLUP];
      next_lp_pend    = is_lp && !lp_enter;
      next_lp_byte    = rx_byte;
      // Low power select leaves slew rate untouched
      if (rx_byte[`SMW_WR_SLEW_HI:`SMW_WR_SLEW_LO] != `SMW_LP_SELECT) begin
        next_slew = rx_byte[`SMW_WR_SLEW_HI:`SMW_WR_SLEW_LO];
      end
    end
    // Reset mode clears the write bits except the pull-up
    if (next_mode == smw_pkg::SMW_RESET) begin
      next_sw_en   = `SMW_SW_EN_RST;
      next_slew    = `SMW_SLEW_RST;
      next_lp_pend = 1'b0;
    end
  end

  always_comb begin
    // clear only after read and fault gone
    next_ov_flag = ov_c | (ov_flag & ~(ov_read & ~ov_c));
    next_uv_flag = uv_c | (uv_flag & ~(uv_read & ~uv_c));
    next_ov_read = next_ov_flag & (ov_read | (cs_fall & ov_flag));
    next_uv_read = next_uv_flag & (uv_read | (cs_fall & uv_flag));
    // Wake source stays until read; a new wake wins over the read
    next_wake_src = cs_fall ? 3'h0 : wake_src;
    if (mode == smw_pkg::SMW_STOP || mode == smw_pkg::SMW_SLEEP) begin
      next_wake_src = next_wake_src | {lin_s & ~lin_prev, wb_s != wb_prev, wa_s != wa_prev};
    end
    // faults and stop wake raise the interrupt
    int_evt = (ov_c & ~ov_flag) | (uv_c & ~uv_flag) | (|(ot_s & ~ot_latch)) |
              (temp_s & ~temp_prev) | (mode == smw_pkg::SMW_STOP && wake_evt);
    next_int_src = int_evt | (int_src & ~cs_fall);
    if (int_evt) begin
      next_int_cnt = 16'(`SMW_INT_PULSE_CYC);
    end else if (int_cnt != 16'h0) begin
      next_int_cnt = int_cnt - 16'h1;
    end else begin
      next_int_cnt = 16'h0;
    end
    next_int_n = (next_int_cnt == 16'h0);
    next_reset_n = vdd_s && (next_mode == smw_pkg::SMW_NORMAL_REQ ||
                             next_mode == smw_pkg::SMW_NORMAL ||
                             next_mode == smw_pkg::SMW_STOP);
    sw_allowed = next_mode == smw_pkg::SMW_NORMAL_REQ || next_mode == smw_pkg::SMW_NORMAL;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mode               <= smw_pkg::SMW_RESET;
      tmr                <= 32'h0;
      wd_cnt             <= 32'h0;
      int_cnt            <= 16'h0;
      int_src            <= 1'b0;
      ov_flag            <= 1'b0;
      uv_flag            <= 1'b0;
      ov_read            <= 1'b0;
      uv_read            <= 1'b0;
      ot_latch           <= 3'h0;
      sw_en              <= `SMW_SW_EN_RST;
      lin_slew           <= `SMW_SLEW_RST;
      pullup_bit         <= `SMW_PULLUP_RST;
      lp_pend            <= 1'b0;
      lp_byte            <= 8'h00;
      wa_prev            <= 1'b0;
      wb_prev            <= 1'b0;
      lin_prev           <= 1'b0;
      temp_prev          <= 1'b0;
      wake_src           <= 3'h0;
      reset_n            <= 1'b0;
      int_n              <= 1'b1;
      regulator_on       <= 1'b1;
      regulator_limited  <= 1'b0;
      high_side_switch_a <= 1'b0;
      high_side_switch_b <= 1'b0;
      high_side_switch_c <= 1'b0;
      amp_enable         <= 1'b0;
      lin_tx_enable      <= 1'b0;
      lin_pullup_off     <= 1'b0;
    end else begin
      mode               <= next_mode;
      tmr                <= next_tmr;
      wd_cnt             <= next_wd_cnt;
      int_cnt            <= next_int_cnt;
      int_src            <= next_int_src;
      ov_flag            <= next_ov_flag;
      uv_flag            <= next_uv_flag;
      ov_read            <= next_ov_read;
      uv_read            <= next_uv_read;
      ot_latch           <= next_ot_latch;
      sw_en              <= next_sw_en;
      lin_slew           <= next_slew;
      pullup_bit         <= next_pullup_bit;
      lp_pend            <= next_lp_pend;
      lp_byte            <= next_lp_byte;
      wa_prev            <= wa_s;
      wb_prev            <= wb_s;
      lin_prev           <= lin_s;
      temp_prev          <= temp_s;
      wake_src           <= next_wake_src;
      reset_n            <= next_reset_n;
      int_n              <= next_int_n;
      regulator_on       <= next_mode != smw_pkg::SMW_SLEEP;
      regulator_limited  <= next_mode == smw_pkg::SMW_STOP;
      // enable AND PWM for a and b, enable only for c; latch forces off
      high_side_switch_a <= sw_allowed & next_sw_en[0] & ~next_ot_latch[0] & pwm_s;
      high_side_switch_b <= sw_allowed & next_sw_en[1] & ~next_ot_latch[1] & pwm_s;
      high_side_switch_c <= sw_allowed & next_sw_en[2] & ~next_ot_latch[2];
      amp_enable         <= next_mode == smw_pkg::SMW_NORMAL;
      lin_tx_enable      <= sw_allowed;
      lin_pullup_off     <= next_pullup_bit &
                            (next_mode == smw_pkg::SMW_STOP || next_mode == smw_pkg::SMW_SLEEP);
    end
  end

endmodule : smw_mode_ctrl

// ===== smw_monitor.sv
// Port checks for the mode and watchdog control
`timescale 1ns/1ns
`include "smw_defs.svh"

module smw_monitor #(
  parameter smw_pkg::smw_count_t RESET_HOLD_CYC = `SMW_RESET_HOLD_CYC  // Reset hold
) (
  input wire logic       clock,              // Clock
  input wire logic       srst,               // Reset
  input wire logic       pwm_in,             // PWM gate
  input wire logic       supply_ov_cond,     // Supply high
  input wire logic       vdd_in_spec,        // Regulator good
  input wire logic [2:0] switch_overtemp,    // Overtemp
  input wire logic       reset_n,            // Reset out
  input wire logic       int_n,              // Interrupt
  input wire logic       regulator_on,       // Regulator on
  input wire logic       regulator_limited,  // Low current
  input wire logic       high_side_switch_a, // Switch a
  input wire logic       high_side_switch_b, // Switch b
  input wire logic       high_side_switch_c, // Switch c
  input wire logic       amp_enable,         // Amplifier
  input wire logic       lin_tx_enable       // LIN active
);
  smw_pkg::smw_count_t low_cnt;
  smw_pkg::smw_count_t int_cnt;
  smw_pkg::smw_count_t next_low_cnt;
  smw_pkg::smw_count_t next_int_cnt;
  logic                any_sw;

  always_comb begin
    next_low_cnt = reset_n ? '0 : low_cnt + 1;
    next_int_cnt = int_n ? '0 : int_cnt + 1;
    any_sw       = high_side_switch_a | high_side_switch_b | high_side_switch_c;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      low_cnt <= '0;
      int_cnt <= '0;
    end else begin
      low_cnt <= next_low_cnt;
      int_cnt <= next_int_cnt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Gate is resynchronised, hence four cycles of low
  chk_gate_a: assert property ((!pwm_in) [*4] |-> !high_side_switch_a)
    else $error("switch a on with gate low");
  chk_gate_b: assert property ((!pwm_in) [*4] |-> !high_side_switch_b)
    else $error("switch b on with gate low");
  chk_hot_off: assert property (switch_overtemp[0] [*4] |-> !high_side_switch_a)
    else $error("switch a on while hot");
  chk_amp_mode: assert property (amp_enable |-> lin_tx_enable && reset_n)
    else $error("amplifier on outside normal");
  chk_stop_off: assert property (regulator_limited |-> !any_sw && !amp_enable)
    else $error("load active in stop");
  chk_sleep_off: assert property (!regulator_on |-> !reset_n && !any_sw)
    else $error("sleep with reset or switch high");
  chk_hold_len: assert property ($rose(reset_n) |-> low_cnt >= RESET_HOLD_CYC)
    else $error("reset released early");
  chk_int_len: assert property ($rose(int_n) |-> int_cnt == `SMW_INT_PULSE_CYC)
    else $error("interrupt pulse length wrong");
  chk_ov_int: assert property ($rose(supply_ov_cond) |-> ##[1:6] !int_n)
    else $error("no interrupt on overvoltage");
  chk_uv_reset: assert property (!vdd_in_spec && amp_enable |-> ##[1:5] !reset_n)
    else $error("no reset on undervoltage");

  cover property ($rose(regulator_limited));
  cover property ($fell(regulator_on));
  cover property ($rose(amp_enable));
endmodule : smw_monitor

bind smw_mode_ctrl smw_monitor #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) smw_monitor_i (
  .clock, .srst, .pwm_in, .supply_ov_cond, .vdd_in_spec, .switch_overtemp, .reset_n,
  .int_n, .regulator_on, .regulator_limited, .high_side_switch_a, .high_side_switch_b,
  .high_side_switch_c, .amp_enable, .lin_tx_enable);

// ===== smw_pkg.sv
// Types shared by the mode and watchdog control
package smw_pkg;

  typedef enum logic [2:0] {
    SMW_RESET,
    SMW_NORMAL_REQ,
    SMW_NORMAL,
    SMW_STOP,
    SMW_SLEEP
  } smw_mode_e;

  typedef logic [31:0] smw_count_t;

endpackage : smw_pkg

// ===== smw_spi_slave.sv
// Eight-bit SPI slave oversampled by the system clock
`timescale 1ns/1ns
`include "smw_defs.svh"

module smw_spi_slave (
  input  wire logic       clock,     // System clock
  input  wire logic       srst,      // Synchronous reset
  input  wire logic       spi_sclk,  // SPI clock pin
  input  wire logic       spi_mosi,  // SPI data in pin
  input  wire logic       spi_csn,   // SPI chip select pin, low active
  input  wire logic [7:0] tx_byte,   // Status loaded at select fall
  output logic      [7:0] rx_byte,   // Last complete byte
  output logic            rx_valid,  // Byte complete pulse
  output logic            cs_fall,   // Select falling pulse
  output logic            cs_rise,   // Select rising pulse
  output logic            spi_miso   // SPI data out
);

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] prev;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [3:0] bit_cnt;
  logic [7:0] next_shift_in;
  logic [7:0] next_shift_out;
  logic [3:0] next_bit_cnt;
  logic [7:0] next_rx_byte;
  logic       next_rx_valid;
  logic       next_miso;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       csn_fall;
  logic       csn_rise;

  // Order: csn, sclk, mosi
  always_ff @(posedge clock) begin
    if (srst) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      prev  <= 3'h7;
    end else begin
      sync1 <= {spi_csn, spi_sclk, spi_mosi};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign sclk_rise = sync2[1] & ~prev[1] & ~sync2[2];
  assign sclk_fall = ~sync2[1] & prev[1] & ~sync2[2];
  assign csn_fall  = ~sync2[2] & prev[2];
  assign csn_rise  = sync2[2] & ~prev[2];

  always_comb begin
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_bit_cnt   = bit_cnt;
    next_rx_byte   = rx_byte;
    next_rx_valid  = 1'b0;
    next_miso      = spi_miso;
    if (csn_fall) begin
      next_shift_out = tx_byte;
      next_bit_cnt   = 4'h0;
      next_miso      = tx_byte[7];
    end else if (sclk_rise) begin
      next_shift_in = {shift_in[6:0], sync2[0]};
      if (bit_cnt != `SMW_SPI_BITS) begin
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end else if (sclk_fall) begin
      next_shift_out = {shift_out[6:0], 1'b0};
      next_miso      = shift_out[6];
    end
    // A frame of eight or more clocks counts with its last eight bits; shorter is dropped
    if (csn_rise && bit_cnt == `SMW_SPI_BITS) begin
      next_rx_byte  = shift_in;
      next_rx_valid = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      shift_in  <= 8'h00;
      shift_out <= 8'h00;
      bit_cnt   <= 4'h0;
      rx_byte   <= 8'h00;
      rx_valid  <= 1'b0;
      cs_fall   <= 1'b0;
      cs_rise   <= 1'b0;
      spi_miso  <= 1'b0;
    end else begin
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
      bit_cnt   <= next_bit_cnt;
      rx_byte   <= next_rx_byte;
      rx_valid  <= next_rx_valid;
      cs_fall   <= csn_fall;
      cs_rise   <= csn_rise;
      spi_miso  <= next_miso;
    end
  end

endmodule : smw_spi_slave

// ===== tb_top.sv
// Self-checking bench for the mode and watchdog control
`timescale 1ns/1ns

module tb_top;
  logic       clock, srst, pwm_in, wake_input_a, wake_input_b, lin_wake, vdd_in_spec;
  logic       supply_ov_cond, supply_uv_cond, wdc_grounded, spi_sclk, spi_mosi, spi_csn;
  logic       spi_miso, reset_n, int_n, regulator_on, regulator_limited, amp_enable;
  logic       high_side_switch_a, high_side_switch_b, high_side_switch_c, lin_tx_enable;
  logic [2:0] switch_overtemp;
  logic       vdd_temp_warn, wdc_open, lin_pullup_off;
  logic [1:0] lin_slew;
  logic [31:0] wd_res_period_cyc;
  logic [7:0] rd;
  int         fail_count, compares;

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  smw_mode_ctrl #(.RESET_HOLD_CYC(50), .NR_TIMEOUT_CYC(400), .WD_DEFAULT_CYC(600))
  smw_mode_ctrl_i (.clock, .srst, .spi_sclk, .spi_mosi, .spi_csn, .spi_miso, .pwm_in,
    .wake_input_a, .wake_input_b, .lin_wake, .supply_ov_cond, .supply_uv_cond, .vdd_in_spec,
    .vdd_temp_warn, .switch_overtemp, .wdc_grounded, .wdc_open,
    .wd_res_period_cyc, .reset_n, .int_n, .regulator_on, .regulator_limited,
    .high_side_switch_a, .high_side_switch_b, .high_side_switch_c, .amp_enable,
    .lin_tx_enable, .lin_pullup_off, .lin_slew);

  smw_host_model smw_host_model_i (.clock, .spi_miso, .spi_sclk, .spi_mosi, .spi_csn);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic spi(input logic [7:0] wr);
    smw_host_model_i.xfer(wr, rd);
  endtask : spi

  task automatic boot(input logic grounded);
    srst = 1'b1;
    wdc_grounded = grounded;
    cyc(16);
    srst = 1'b0;
    cyc(40);
    chk(8'(reset_n), 8'h0);
    cyc(20);
    chk({6'h0, reset_n, lin_tx_enable}, 8'h3);
  endtask : boot

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  initial begin
    #400000;
    fail_count++;
    $display("FAIL %0t ns: run did not finish", $time);
    final_report();
  end

  initial begin
    {srst, pwm_in, vdd_in_spec} = 3'h7;
    {wake_input_a, wake_input_b, lin_wake, supply_ov_cond, supply_uv_cond} = 5'h0;
    switch_overtemp = 3'h0;
    vdd_temp_warn = 1'b0;
    wdc_open = 1'b1;
    wd_res_period_cyc = 32'h3e8;
    boot(1'b1);
    spi(8'h1e);
    chk({4'h0, amp_enable, high_side_switch_c, high_side_switch_b, high_side_switch_a}, 8'hf);
    pwm_in = 1'b0;
    cyc(5);
    chk({5'h0, high_side_switch_c, high_side_switch_b, high_side_switch_a}, 8'h4);
    pwm_in = 1'b1;
    switch_overtemp = 3'h1;
    wake_input_a = 1'b1;
    cyc(10);
    switch_overtemp = 3'h0;
    cyc(5);
    chk({5'h0, high_side_switch_c, high_side_switch_b, high_side_switch_a}, 8'h6);
    spi(8'h5e);
    chk({5'h0, rd[7], rd[2], rd[0]}, 8'h7);
    chk({5'h0, lin_slew, high_side_switch_a}, 8'h3);
    $display("switch test done");
    cyc(1300);
    vdd_temp_warn = 1'b1;
    cyc(6);
    chk(8'(int_n), 8'h0);
    vdd_temp_warn = 1'b0;
    cyc(1300);
    for (int i = 0; i < 2; i++) begin
      {supply_ov_cond, supply_uv_cond} = (i == 0) ? 2'h2 : 2'h1;
      cyc(6);
      chk(8'(int_n), 8'h0);
      {supply_ov_cond, supply_uv_cond} = 2'h0;
      spi(8'h1e);
      chk(8'(rd[5 - i]), 8'h1);
      spi(8'h1e);
      chk(8'(rd[5 - i]), 8'h0);
      cyc(1300);
    end
    chk(8'(reset_n), 8'h1);
    $display("supply test done");
    spi(8'hfd);
    chk(8'(regulator_limited), 8'h0);
    spi(8'hfd);
    chk({4'h0, lin_pullup_off, regulator_limited, amp_enable, high_side_switch_a}, 8'hc);
    wake_input_b = 1'b1;
    cyc(6);
    chk({5'h0, int_n, lin_tx_enable, regulator_limited}, 8'h2);
    spi(8'h1e);
    spi(8'hdc);
    spi(8'hdc);
    chk({6'h0, regulator_on, reset_n}, 8'h0);
    // Let the stop wake pulse end first
    cyc(800);
    lin_wake = 1'b1;
    cyc(10);
    chk({4'h0, regulator_on, reset_n, int_n, lin_tx_enable}, 8'hf);
    spi(8'h1e);
    spi(8'hdd);
    spi(8'hdd);
    spi(8'h1e);
    chk({6'h0, lin_tx_enable, regulator_limited}, 8'h2);
    spi(8'h1e);
    vdd_in_spec = 1'b0;
    cyc(6);
    chk(8'(reset_n), 8'h0);
    vdd_in_spec = 1'b1;
    $display("mode test done");
    boot(1'b0);
    cyc(420);
    chk(8'(reset_n), 8'h0);
    cyc(60);
    spi(8'h1e);
    cyc(200);
    spi(8'h1e);
    chk(8'(reset_n), 8'h1);
    spi(8'h1e);
    cyc(2);
    chk(8'(reset_n), 8'h0);
    cyc(60);
    spi(8'h1e);
    cyc(620);
    chk(8'(reset_n), 8'h0);
    wdc_open = 1'b0;
    cyc(60);
    spi(8'h1e);
    cyc(620);
    chk(8'(reset_n), 8'h1);
    cyc(400);
    chk(8'(reset_n), 8'h0);
    $display("watchdog test done");
    final_report();
  end
endmodule : tb_top
